// ===== include/sram_ctl_pkg.sv
/*
  package for the asynchronous sram module controller: pin timing figures,
  derived cycle counts, widths and the packed structs that carry requests and strobes.
  assumes a 50 MHz system clock and the fastest speed grade of the module.
*/
package sram_ctl_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  // pin timing figures in ns
  localparam int READ_CYCLE_MIN_NS = 10;
  localparam int SELECT_ACCESS_MAX_NS = 10;
  localparam int DRIVE_TO_VALID_MAX_NS = 5;
  localparam int ADDR_CHANGE_HOLD_MIN_NS = 3;
  localparam int DESELECT_FLOAT_MAX_NS = 5;
  localparam int SELECT_DRIVE_MIN_NS = 2;
  localparam int WRITE_CYCLE_MIN_NS = 10;
  localparam int SELECT_TO_WRITE_END_MIN_NS = 8;
  localparam int ADDR_TO_WRITE_END_MIN_NS = 9;
  localparam int ADDR_SETUP_MIN_NS = 1;
  localparam int WRITE_PULSE_MIN_NS = 8;
  localparam int WRITE_RECOVERY_MIN_NS = 0;
  localparam int STROBE_FLOAT_MAX_NS = 5;
  localparam int DATA_OVERLAP_MIN_NS = 5;
  localparam int DATA_HOLD_MIN_NS = 1;
  localparam int DRIVE_AFTER_WRITE_MIN_NS = 2;
  // least times round up, at least one cycle
  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  // wait for the slower of access and drive paths before sampling
  localparam int READ_ACCESS_CYC = ceil_cyc(
    (SELECT_ACCESS_MAX_NS > DRIVE_TO_VALID_MAX_NS) ?
    SELECT_ACCESS_MAX_NS : DRIVE_TO_VALID_MAX_NS);
  localparam int READ_FLOAT_CYC = ceil_cyc(DESELECT_FLOAT_MAX_NS);
  localparam int PULSE_NEED_NS =
    (WRITE_PULSE_MIN_NS > STROBE_FLOAT_MAX_NS + DATA_OVERLAP_MIN_NS) ?
    WRITE_PULSE_MIN_NS : STROBE_FLOAT_MAX_NS + DATA_OVERLAP_MIN_NS;
  localparam int WRITE_PULSE_CYC = ceil_cyc(
    (PULSE_NEED_NS > SELECT_TO_WRITE_END_MIN_NS) ?
    PULSE_NEED_NS : SELECT_TO_WRITE_END_MIN_NS);
  localparam int ADDR_SETUP_CYC = ceil_cyc(ADDR_SETUP_MIN_NS);
  localparam int DATA_HOLD_CYC = ceil_cyc(DATA_HOLD_MIN_NS);
  // the pin bus passes three flops; select stands one sample past the
  // access so two stages see the same word, then the chain drains
  localparam int SYNC_STAGES = 3;
  localparam int READ_SELECT_CYC = READ_ACCESS_CYC + 1;
  localparam int READ_SETTLE_CYC = (READ_FLOAT_CYC > SYNC_STAGES - 1) ?
    READ_FLOAT_CYC : SYNC_STAGES - 1;
  localparam int CNT_W = 4;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [LANES-1:0] lanes;
  } req_t;

  typedef struct packed {
    logic [LANES-1:0] cs_n;
    logic we_n;
    logic oe_n;
  } strobe_t;
endpackage

// ===== src/sram_ctl.sv
/*
  host controller for the 32-bit asynchronous sram module: takes one read
  or write request at a time and sequences address, strobes and data pins.
  assumes the module is wired to these pins with no extra logic between,
  and that the bench resolves the data bus from o_dq_oe.
*/
`timescale 1ns/1ps
module sram_ctl (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // request side
  input wire logic i_req_valid,
  input wire sram_ctl_pkg::req_t i_req,
  output logic o_req_ready,
  output logic o_rd_valid,
  output logic [sram_ctl_pkg::DATA_W-1:0] o_rd_data,
  // memory pins
  output logic [sram_ctl_pkg::ADDR_W-1:0] o_addr,
  output sram_ctl_pkg::strobe_t o_strb,
  output logic [sram_ctl_pkg::DATA_W-1:0] o_dq_out,
  output logic o_dq_oe,
  input wire logic [sram_ctl_pkg::DATA_W-1:0] i_dq_in
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_RD_WAIT, ST_RD_FLOAT, ST_WR_PULSE, ST_WR_HOLD
  } state_t;

  localparam logic [sram_ctl_pkg::CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [sram_ctl_pkg::CNT_W-1:0] SETUP_N =
    sram_ctl_pkg::CNT_W'(sram_ctl_pkg::ADDR_SETUP_CYC);
  // select stands one sample past the access so stages two and three
  // of the pin synchroniser can agree on the read word
  localparam logic [sram_ctl_pkg::CNT_W-1:0] SELECT_N =
    sram_ctl_pkg::CNT_W'(sram_ctl_pkg::READ_SELECT_CYC);
  // after deselect: float time, and the chain must carry the last sample
  localparam logic [sram_ctl_pkg::CNT_W-1:0] SETTLE_N =
    sram_ctl_pkg::CNT_W'(sram_ctl_pkg::READ_SETTLE_CYC);
  localparam logic [sram_ctl_pkg::CNT_W-1:0] PULSE_N =
    sram_ctl_pkg::CNT_W'(sram_ctl_pkg::WRITE_PULSE_CYC);
  localparam logic [sram_ctl_pkg::CNT_W-1:0] HOLD_N =
    sram_ctl_pkg::CNT_W'(sram_ctl_pkg::DATA_HOLD_CYC);
  localparam logic [sram_ctl_pkg::LANES-1:0] LANES_OFF = 4'hF;

  // the three-stage sampling of the pin bus; only stage two reads stage
  // one, so a metastable first stage never reaches the state machine
  logic [sram_ctl_pkg::DATA_W-1:0] dq_s1_q, dq_s2_q, dq_s3_q;

  state_t state_q, state_d;
  logic [sram_ctl_pkg::CNT_W-1:0] cnt_q, cnt_d;
  sram_ctl_pkg::req_t req_q, req_d;
  logic ready_q, ready_d;
  logic rd_valid_q, rd_valid_d;
  logic [sram_ctl_pkg::DATA_W-1:0] rd_data_q, rd_data_d;
  logic [sram_ctl_pkg::ADDR_W-1:0] addr_q, addr_d;
  sram_ctl_pkg::strobe_t strb_q, strb_d;
  logic [sram_ctl_pkg::DATA_W-1:0] dq_out_q, dq_out_d;
  logic dq_oe_q, dq_oe_d;
  logic cnt_done;
  logic dq_agree;

  assign cnt_done = (cnt_q == CNT_ONE);
  // a pin word counts only once stages two and three agree
  assign dq_agree = (dq_s2_q == dq_s3_q);

  // next-state and pin values; pins only move on state boundaries
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_done ? cnt_q : cnt_q - CNT_ONE;
    req_d = req_q;
    ready_d = ready_q;
    rd_valid_d = 1'b0;
    rd_data_d = rd_data_q;
    addr_d = addr_q;
    strb_d = strb_q;
    dq_out_d = dq_out_q;
    dq_oe_d = dq_oe_q;
    unique case (state_q)
      ST_IDLE: begin
        if (i_req_valid && ready_q) begin
          // address moves only with all strobes high
          req_d = i_req;
          addr_d = i_req.addr;
          dq_out_d = i_req.wdata;
          dq_oe_d = i_req.we; // bus ours before the strobe falls
          ready_d = 1'b0;
          cnt_d = SETUP_N;
          state_d = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cnt_done) begin
          if (req_q.we) begin
            // select and strobe fall together, so the memory never drives
            strb_d.cs_n = ~req_q.lanes;
            strb_d.we_n = 1'b0;
            strb_d.oe_n = 1'b1;
            cnt_d = PULSE_N;
            state_d = ST_WR_PULSE;
          end else begin
            // full word read; byte lanes only matter for writes
            strb_d.cs_n = ~LANES_OFF;
            strb_d.we_n = 1'b1;
            strb_d.oe_n = 1'b0;
            cnt_d = SELECT_N;
            state_d = ST_RD_WAIT;
          end
        end
      end
      ST_RD_WAIT: begin
        // slowest output delay spent and sampled twice; the cycle is far
        // longer than the read minimum, traded for a simple sample point
        if (cnt_done) begin
          strb_d.cs_n = LANES_OFF;
          strb_d.oe_n = 1'b1;
          cnt_d = SETTLE_N;
          state_d = ST_RD_FLOAT;
        end
      end
      ST_RD_FLOAT: begin
        // data taken from the synchroniser once its last two stages agree
        if (cnt_done) begin
          if (dq_agree) begin
            rd_data_d = dq_s3_q;
            rd_valid_d = 1'b1;
            ready_d = 1'b1;
            state_d = ST_IDLE;
          end else begin
            // bus moved under the sample: select again, never a torn word
            cnt_d = SETUP_N;
            state_d = ST_SETUP;
          end
        end
      end
      ST_WR_PULSE: begin
        if (cnt_done) begin
          // select and strobe rise together ending the write
          strb_d.cs_n = LANES_OFF;
          strb_d.we_n = 1'b1;
          cnt_d = HOLD_N;
          state_d = ST_WR_HOLD;
        end
      end
      ST_WR_HOLD: begin
        // bus released only after data hold and memory drive-after-write;
        // the memory cannot drive here anyway, its output drive is high
        if (cnt_done) begin
          dq_oe_d = 1'b0;
          ready_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // register everything; pins come straight from flops
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      cnt_q <= CNT_ONE;
      req_q <= '0;
      ready_q <= 1'b1;
      rd_valid_q <= 1'b0;
      rd_data_q <= '0;
      addr_q <= '0;
      strb_q <= '1;
      dq_out_q <= '0;
      dq_oe_q <= 1'b0;
      dq_s1_q <= '0;
      dq_s2_q <= '0;
      dq_s3_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      req_q <= req_d;
      ready_q <= ready_d;
      rd_valid_q <= rd_valid_d;
      rd_data_q <= rd_data_d;
      addr_q <= addr_d;
      strb_q <= strb_d;
      dq_out_q <= dq_out_d;
      dq_oe_q <= dq_oe_d;
      dq_s1_q <= i_dq_in;
      dq_s2_q <= dq_s1_q;
      dq_s3_q <= dq_s2_q;
    end
  end

  // pins and results leave straight from the flops
  assign o_req_ready = ready_q;
  assign o_rd_valid = rd_valid_q;
  assign o_rd_data = rd_data_q;
  assign o_addr = addr_q;
  assign o_strb = strb_q;
  assign o_dq_out = dq_out_q;
  assign o_dq_oe = dq_oe_q;

endmodule // sram_ctl

// ===== sim/sram_ctl_sva.sv
/*
  pin timing checks for the sram controller.
  assumes one 50 MHz clock and synchronous reset.
*/
`timescale 1ns/1ps
module sram_ctl_sva (
  // controller ports
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic o_req_ready,
  input wire logic o_rd_valid,
  input wire logic [sram_ctl_pkg::ADDR_W-1:0] o_addr,
  input wire sram_ctl_pkg::strobe_t o_strb,
  input wire logic [sram_ctl_pkg::DATA_W-1:0] o_dq_out,
  input wire logic o_dq_oe
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // reads
  chk_read_we_high: assert property (!o_strb.oe_n |-> o_strb.we_n)
    else $error("strobe low in read");
  chk_addr_quiet: assert property ($changed(o_addr) |->
    &o_strb.cs_n && o_strb.we_n && $past(o_strb.we_n))
    else $error("address moved while selected");
  chk_sel_addr: assert property ($fell(o_strb.oe_n) |->
    $stable(o_addr) && o_strb.cs_n == 4'h0)
    else $error("address not set before select");
  // select stands two samples, then the chain drains before the result
  chk_read_span: assert property ($fell(o_strb.oe_n) |=>
    !o_strb.oe_n ##1 (o_strb.oe_n && &o_strb.cs_n) ##1 !o_rd_valid
    ##1 (o_rd_valid && o_req_ready) ##1 !o_rd_valid)
    else $error("read sequence wrong");
  chk_bus_turn: assert property (!o_strb.oe_n |-> !o_dq_oe)
    else $error("bus fight in read");
  // writes
  chk_wr_overlap: assert property ($fell(o_strb.we_n) |->
    o_strb.cs_n != 4'hF ##1 $rose(o_strb.we_n))
    else $error("write pulse wrong");
  chk_wr_setup: assert property ($fell(o_strb.we_n) |->
    o_dq_oe && $stable(o_addr) && $stable(o_dq_out))
    else $error("write setup short");
  chk_wr_hold: assert property ($rose(o_strb.we_n) |->
    o_dq_oe && $stable(o_dq_out) && $stable(o_addr))
    else $error("write hold short");
  chk_wr_oe_off: assert property (!o_strb.we_n |-> o_strb.oe_n)
    else $error("drive low in write");
  chk_wr_gap: assert property ($rose(o_strb.we_n) |=> o_strb.we_n [*2])
    else $error("writes too close");
  cover property ($fell(o_strb.we_n) && o_strb.cs_n != 4'h0);
  cover property (o_rd_valid);
  cover property ($rose(o_strb.we_n) ##3 !o_strb.oe_n);
endmodule // sram_ctl_sva

bind sram_ctl sram_ctl_sva sram_ctl_sva_inst (.i_sys_clk, .i_rst,
  .o_req_ready, .o_rd_valid, .o_addr, .o_strb, .o_dq_out, .o_dq_oe);

// ===== sim/sram_model.sv
/*
  behavioural model of the clockless sram module.
  assumes the bench resolves the data bus from both drivers.
*/
`timescale 1ns/1ps
module sram_model #(
  parameter int ACC_NS = sram_ctl_pkg::SELECT_ACCESS_MAX_NS,
  parameter int HOLD_NS = sram_ctl_pkg::DESELECT_FLOAT_MAX_NS
) (
  // pins from the controller
  input wire logic [15:0] i_addr,
  input wire sram_ctl_pkg::strobe_t i_strb,
  input wire logic [31:0] i_dq,
  // data the module drives
  output logic [31:0] o_dq
);
  logic [31:0] mem [0:65535];
  logic [3:0] lanes_q = 4'h0;
  logic on;
  initial o_dq = 32'h0;
  // drives only in a read; a write strobe keeps it floating
  assign on = i_strb.cs_n == 4'h0 && !i_strb.oe_n && i_strb.we_n;
  // no clock: pin edges only; a released bus shows the inverse word at
  // the latest float time, so a late sample cannot pass by luck
  always @(on, i_addr) begin
    if (on) o_dq <= #(ACC_NS) mem[i_addr];
    else o_dq <= #(HOLD_NS) ~o_dq;
  end
  // lanes from select at strobe fall, stored at strobe rise
  always @(negedge i_strb.we_n) lanes_q = ~i_strb.cs_n;
  always @(posedge i_strb.we_n)
    for (int i = 0; i < 4; i++)
      if (lanes_q[i]) mem[i_addr][8*i +: 8] = i_dq[8*i +: 8];
endmodule // sram_model

// ===== sim/async_sram_module_access_bench.sv
/*
  self-checking bench for the sram controller with a module model.
  assumes the controller handshake: ready, take edge, result edges.
*/
`timescale 1ns/1ps
module async_sram_module_access_bench;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic req_v = 1'b0;
  sram_ctl_pkg::req_t req = '0;
  sram_ctl_pkg::strobe_t strb;
  logic ready, rd_v, dq_oe;
  logic [15:0] addr;
  logic [31:0] rd_d, dq_out, dev_q, dq_bus, got;
  int n_mismatch = 0;
  int checked = 0;
  always #10 i_sys_clk = ~i_sys_clk;
  assign dq_bus = dq_oe ? dq_out : dev_q;
  sram_ctl sram_ctl_inst (.i_sys_clk, .i_rst, .i_req_valid(req_v),
    .i_req(req), .o_req_ready(ready), .o_rd_valid(rd_v), .o_rd_data(rd_d),
    .o_addr(addr), .o_strb(strb), .o_dq_out(dq_out), .o_dq_oe(dq_oe),
    .i_dq_in(dq_bus));
  sram_model sram_model_inst (.i_addr(addr), .i_strb(strb), .i_dq(dq_bus),
    .o_dq(dev_q));
  task automatic chk(input string what, input logic [31:0] exp, seen);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one request; writes and reads both time the answer
  task automatic access(input logic w, input logic [15:0] a,
    input logic [31:0] d, input logic [3:0] l);
    int n;
    int busy;
    n = 0;
    // edges from take to result: setup, then select and settle, or pulse and hold
    busy = sram_ctl_pkg::ADDR_SETUP_CYC + (w ?
      sram_ctl_pkg::WRITE_PULSE_CYC + sram_ctl_pkg::DATA_HOLD_CYC :
      sram_ctl_pkg::READ_SELECT_CYC + sram_ctl_pkg::READ_SETTLE_CYC);
    @(negedge i_sys_clk);
    while (ready !== 1'b1) @(negedge i_sys_clk);
    req_v <= 1'b1;
    req <= {w, a, d, l};
    @(negedge i_sys_clk);
    req_v <= 1'b0;
    // reads end on the valid pulse, writes when ready returns
    while ((w ? ready : rd_v) !== 1'b1 && n < 20) begin
      @(posedge i_sys_clk);
      #1 n++;
    end
    if (w) begin
      chk("write busy", 32'(busy), 32'(n));
    end else begin
      chk("read latency", 32'(busy), 32'(n));
      got = rd_d;
    end
  endtask
  task automatic t_idle();
    chk("idle pins", 32'hBF, 32'({ready, dq_oe, strb}));
  endtask
  task automatic t_word();
    access(1'b1, 16'h0012, 32'hA5A5_5A5A, 4'hF);
    access(1'b0, 16'h0012, 32'h0, 4'hF);
    chk("full word", 32'hA5A5_5A5A, got);
  endtask
  task automatic t_lanes();
    access(1'b1, 16'h0012, 32'h1122_3344, 4'h5);
    access(1'b0, 16'h0012, 32'h0, 4'hF);
    chk("lane merge", 32'hA522_5A44, got);
  endtask
  // edge addresses, reads back to back so the old data must not linger
  task automatic t_b2b();
    access(1'b1, 16'hFFFF, 32'hFFFF_0000, 4'hF);
    access(1'b1, 16'h0000, 32'h0000_FFFF, 4'hF);
    access(1'b0, 16'hFFFF, 32'h0, 4'hF);
    chk("top word", 32'hFFFF_0000, got);
    access(1'b0, 16'h0000, 32'h0, 4'hF);
    chk("bottom word", 32'h0000_FFFF, got);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge i_sys_clk);
    i_rst <= 1'b0;
    @(negedge i_sys_clk);
    t_idle();
    t_word();
    t_lanes();
    t_b2b();
    give_verdict();
  end
  // about 45 cycles of work; far longer means a hang
  initial begin
    #20000;
    n_mismatch++;
    give_verdict();
  end
endmodule // async_sram_module_access_bench
